// >>> include/lfd_pkg.sv
package lfd_pkg;
   localparam int NUM_CH = 16;
   localparam int REG_W = 8;
   localparam int OT_CLR_BIT = 7;
   localparam logic [REG_W-1:0] MODE_RESET = 8'h00;
   localparam logic [NUM_CH-1:0] CH_ZERO = 16'h0000;
   localparam int LOW_LSB = 0;
   localparam int HIGH_LSB = 8;
   // minimum reset low time, taken by the asynchronous reset path
   localparam int RESET_PULSE_NS = 10;
   localparam int SPIKE_NS = 50;
   localparam int LINK_PERIOD_NS = 32;
   // a spike shorter than SPIKE_NS can span this many link edges
   localparam int SPIKE_CYC = (SPIKE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam int SPIKE_CW = 2;
   // so a change must be seen on one sample more than that before it is accepted
   localparam logic [SPIKE_CW-1:0] SPIKE_LAST = SPIKE_CW'(SPIKE_CYC);
   localparam logic [SPIKE_CW-1:0] CNT_ZERO = 2'h0;
   localparam logic [SPIKE_CW-1:0] CNT_ONE = 2'h1;
   localparam int NUM_LINES = 2;
   localparam logic [NUM_LINES-1:0] LINES_IDLE = 2'h3;
endpackage : lfd_pkg

// >>> src/lfd_spike_filter.sv
module lfd_spike_filter
   import lfd_pkg::*;
(
   input wire logic link_clk,
   input wire logic rst_n,
   input wire logic [NUM_LINES-1:0] line_raw,
   output logic [NUM_LINES-1:0] line_clean
);
   logic lrst_meta;
   logic lrst_sync;
   logic [NUM_LINES-1:0] line_meta;
   logic [NUM_LINES-1:0] line_sync;

   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         lrst_meta <= 1'b0;
         lrst_sync <= 1'b0;
      end else begin
         lrst_meta <= 1'b1;
         lrst_sync <= lrst_meta;
      end
   end

   always_ff @(posedge link_clk or negedge lrst_sync) begin
      if (!lrst_sync) begin
         line_meta <= LINES_IDLE;
         line_sync <= LINES_IDLE;
      end else begin
         line_meta <= line_raw;
         line_sync <= line_meta;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_LINES; g++) begin : g_line
         logic [SPIKE_CW-1:0] stable_cnt;
         always_ff @(posedge link_clk or negedge lrst_sync) begin
            if (!lrst_sync) begin
               stable_cnt <= CNT_ZERO;
               line_clean[g] <= LINES_IDLE[g];
            end else if (line_sync[g] == line_clean[g]) begin
               stable_cnt <= CNT_ZERO;
            end else if (stable_cnt == SPIKE_LAST) begin
               stable_cnt <= CNT_ZERO;
               line_clean[g] <= line_sync[g];
            end else begin
               stable_cnt <= stable_cnt + CNT_ONE;
            end
         end

         property p_spike_reject;
            @(posedge link_clk) disable iff (!lrst_sync)
               $changed(line_clean[g]) |-> $past(line_sync[g], 1) == line_clean[g]
                  && $past(line_sync[g], 2) == line_clean[g]
                  && $past(line_sync[g], 3) == line_clean[g];
         endproperty
         a_spike_reject: assert property (p_spike_reject)
            else $error("filtered line changed on a short pulse");
      end
   endgenerate
endmodule : lfd_spike_filter

// >>> src/lfd_fault_ctrl.sv
module lfd_fault_ctrl
   import lfd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [NUM_CH-1:0] led_on,
   input wire logic [NUM_CH-1:0] pwm_active,
   input wire logic [NUM_CH-1:0] cur_ok,
   input wire logic ot_global,
   input wire logic [NUM_CH-1:0] ot_chan,
   input wire logic mode_wr,
   input wire logic [REG_W-1:0] mode_wdata,
   output logic [NUM_CH-1:0] drive_en,
   output logic [REG_W-1:0] error_flags_low,
   output logic [REG_W-1:0] error_flags_high,
   output logic [REG_W-1:0] second_mode_register,
   output logic [NUM_CH-1:0] ot_status,
   output logic scl_filt,
   output logic sda_filt
);
   logic rst_meta;
   logic rst_sync;
   logic [NUM_LINES-1:0] line_clean;
   logic [NUM_LINES-1:0] line_meta;
   logic [NUM_CH-1:0] cur_ok_meta;
   logic [NUM_CH-1:0] cur_ok_s;
   logic [NUM_CH-1:0] ot_chan_meta;
   logic [NUM_CH-1:0] ot_chan_s;
   logic ot_global_meta;
   logic ot_global_s;
   logic [NUM_CH-1:0] ol_ok;
   logic [NUM_CH-1:0] next_drive;
   logic [NUM_CH-1:0] next_ol_ok;
   logic [NUM_CH-1:0] next_ot;
   logic [NUM_CH-1:0] next_flags;
   logic ot_armed;
   logic ot_clear;

   // reset asserts at once, however short the low pulse, and releases on the clock
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // serial lines are filtered in the link domain
   lfd_spike_filter u_filter (
      .link_clk(link_clk),
      .rst_n(rst_n),
      .line_raw({sda_in, scl_in}),
      .line_clean(line_clean)
   );

   // filtered levels cross into the reference domain
   always_ff @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         line_meta <= LINES_IDLE;
         scl_filt <= LINES_IDLE[0];
         sda_filt <= LINES_IDLE[1];
      end else begin
         line_meta <= line_clean;
         scl_filt <= line_meta[0];
         sda_filt <= line_meta[1];
      end
   end

   // sensor and comparator levels are asynchronous to this clock
   always_ff @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         cur_ok_meta <= CH_ZERO;
         cur_ok_s <= CH_ZERO;
         ot_chan_meta <= CH_ZERO;
         ot_chan_s <= CH_ZERO;
         ot_global_meta <= 1'b0;
         ot_global_s <= 1'b0;
      end else begin
         cur_ok_meta <= cur_ok;
         cur_ok_s <= cur_ok_meta;
         ot_chan_meta <= ot_chan;
         ot_chan_s <= ot_chan_meta;
         ot_global_meta <= ot_global;
         ot_global_s <= ot_global_meta;
      end
   end

   // mode register: bit 7 both clears and disarms overtemperature flagging
   always_ff @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         second_mode_register <= MODE_RESET;
      end else if (mode_wr) begin
         second_mode_register <= mode_wdata;
      end
   end

   assign ot_clear = second_mode_register[OT_CLR_BIT];
   assign ot_armed = !second_mode_register[OT_CLR_BIT];

   always_comb begin
      // output latch drives unless a sensor is tripped; restart is automatic
      next_drive = led_on & ~ot_chan_s & ~{NUM_CH{ot_global_s}};
      for (int i = 0; i < NUM_CH; i++) begin
         if (next_drive[i] && !pwm_active[i]) begin
            next_ol_ok[i] = cur_ok_s[i];
         end else if (next_drive[i]) begin
            next_ol_ok[i] = ol_ok[i];
         end else begin
            next_ol_ok[i] = 1'b0;
         end
      end
      if (ot_clear) begin
         next_ot = CH_ZERO;
      end else if (ot_armed && ot_global_s) begin
         next_ot = {NUM_CH{1'b1}};
      end else if (ot_armed) begin
         next_ot = ot_status | (ot_chan_s & led_on);
      end else begin
         next_ot = ot_status;
      end
      next_flags = next_drive & next_ol_ok & ~next_ot;
   end

   always_ff @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         drive_en <= CH_ZERO;
         ol_ok <= CH_ZERO;
         ot_status <= CH_ZERO;
      end else begin
         drive_en <= next_drive;
         ol_ok <= next_ol_ok;
         ot_status <= next_ot;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         error_flags_low <= MODE_RESET;
         error_flags_high <= MODE_RESET;
      end else begin
         error_flags_low <= next_flags[LOW_LSB +: REG_W];
         error_flags_high <= next_flags[HIGH_LSB +: REG_W];
      end
   end

   property p_global_off;
      @(posedge ref_clk) disable iff (!rst_sync)
         ot_global_s |=> drive_en == CH_ZERO;
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("channel still driven during global overtemperature");

   property p_global_flags;
      @(posedge ref_clk) disable iff (!rst_sync)
         ot_global_s |=> error_flags_low == MODE_RESET && error_flags_high == MODE_RESET;
   endproperty
   a_global_flags: assert property (p_global_flags)
      else $error("status not zero during global overtemperature");

   property p_restart;
      @(posedge ref_clk) disable iff (!rst_sync)
         !ot_global_s && ot_chan_s == CH_ZERO |=> drive_en == $past(led_on);
   endproperty
   a_restart: assert property (p_restart)
      else $error("channel did not follow its latch when cool");

   property p_persist;
      @(posedge ref_clk) disable iff (!rst_sync)
         !second_mode_register[OT_CLR_BIT] |=> ($past(ot_status) & ~ot_status) == CH_ZERO;
   endproperty
   a_persist: assert property (p_persist)
      else $error("overtemperature status dropped without a clear");

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_sync)
         second_mode_register[OT_CLR_BIT] |=> ot_status == CH_ZERO;
   endproperty
   a_clear: assert property (p_clear)
      else $error("overtemperature status not cleared by mode bit");

   property p_armed;
      @(posedge ref_clk) disable iff (!rst_sync)
         !second_mode_register[OT_CLR_BIT] && ot_global_s |=> ot_status == ~CH_ZERO;
   endproperty
   a_armed: assert property (p_armed)
      else $error("armed global overtemperature not latched");

   // a driven channel under modulation keeps its last open-load result
   property p_pwm_hold;
      @(posedge ref_clk) disable iff (!rst_sync)
         1'b1 |=> ((ol_ok ^ $past(ol_ok)) & $past(next_drive & pwm_active)) == CH_ZERO;
   endproperty
   a_pwm_hold: assert property (p_pwm_hold)
      else $error("open-load result changed under modulation");

   property p_chan_only;
      @(posedge ref_clk) disable iff (!rst_sync)
         !ot_global_s |=> drive_en == ($past(led_on) & ~$past(ot_chan_s))
            && ({error_flags_high, error_flags_low} & $past(ot_chan_s)) == CH_ZERO;
   endproperty
   a_chan_only: assert property (p_chan_only)
      else $error("channel overtemperature affected the wrong channels");

   property p_off_no_ot;
      @(posedge ref_clk) disable iff (!rst_sync)
         !ot_global_s |=> (ot_status & ~$past(ot_status) & ~$past(led_on)) == CH_ZERO;
   endproperty
   a_off_no_ot: assert property (p_off_no_ot)
      else $error("overtemperature recorded on an off channel");

   property p_open_load;
      @(posedge ref_clk) disable iff (!rst_sync)
         next_drive[0] && !pwm_active[0] && !cur_ok_s[0] |=> !ol_ok[0] && !error_flags_low[0];
   endproperty
   a_open_load: assert property (p_open_load)
      else $error("open load not reported");

   property p_flag_or;
      @(posedge ref_clk) disable iff (!rst_sync)
         ({error_flags_high, error_flags_low} & (~ol_ok | ot_status)) == CH_ZERO;
   endproperty
   a_flag_or: assert property (p_flag_or)
      else $error("flag set despite a fault");

   property p_off_zero;
      @(posedge ref_clk) disable iff (!rst_sync)
         ({error_flags_high, error_flags_low} & ~drive_en) == CH_ZERO;
   endproperty
   a_off_zero: assert property (p_off_zero)
      else $error("status 1 on an off channel");

   property p_good_one;
      @(posedge ref_clk) disable iff (!rst_sync)
         led_on[1] && !pwm_active[1] && cur_ok_s[1] && !ot_chan_s[1] && !ot_global_s
            && !ot_status[1] |=> error_flags_low[1];
   endproperty
   a_good_one: assert property (p_good_one)
      else $error("healthy channel not reported as 1");
endmodule : lfd_fault_ctrl

// >>> tb/lfd_host.sv
module lfd_host (
   input wire logic link_clk,
   input wire logic start,
   input wire logic [3:0] low_cyc,
   input wire logic [1:0] pull,
   output logic scl_in,
   output logic sda_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev = 1'b0;
   logic [3:0] cnt = 4'h0;
   // a toggle of start pulls the lines chosen by pull low for low_cyc link cycles
   always @(posedge link_clk) begin
      prev <= start;
      if (start != prev) begin
         cnt <= low_cyc;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
   // released lines return to the pull-up level
   assign scl_in = !(pull[0] && cnt != 4'h0);
   assign sda_in = !(pull[1] && cnt != 4'h0);
endmodule : lfd_host

// >>> tb/lfd_fault_ctrl_bench.sv
module lfd_fault_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import lfd_pkg::*;
   logic ref_clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
   logic [15:0] led_on = 16'h0000, pwm_active = 16'h0000, cur_ok = 16'h0000, ot_chan = 16'h0000;
   logic ot_global = 1'b0, mode_wr = 1'b0, go = 1'b0;
   logic [1:0] pull = 2'h0, acc;
   logic [7:0] mode_wdata = 8'h00;
   logic [3:0] len = 4'h0;
   logic [15:0] drive_en, ot_status, e_d, e_f, e_o;
   logic [7:0] error_flags_low, error_flags_high, second_mode_register;
   logic scl_in, sda_in, scl_filt, sda_filt;
   int n_mismatch = 0, total_checks = 0;
   logic [111:0] rows [7] = '{
      {16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000},
      {16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000},
      {16'hFFFF, 16'h0000, 16'hFF00, 16'h0000, 16'hFFFF, 16'hFF00, 16'h0000},
      {16'h00F0, 16'h0000, 16'hFFFF, 16'h0000, 16'h00F0, 16'h00F0, 16'h0000},
      {16'hFFFF, 16'h0000, 16'hFFFF, 16'h0004, 16'hFFFB, 16'hFFFB, 16'h0004},
      {16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFB, 16'h0004},
      {16'hFFF0, 16'h0000, 16'hFFFF, 16'h0008, 16'hFFF0, 16'hFFF0, 16'h0004}};

   lfd_fault_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .link_clk(link_clk), .scl_in(scl_in),
      .sda_in(sda_in), .led_on(led_on), .pwm_active(pwm_active), .cur_ok(cur_ok),
      .ot_global(ot_global), .ot_chan(ot_chan), .mode_wr(mode_wr), .mode_wdata(mode_wdata),
      .drive_en(drive_en), .error_flags_low(error_flags_low), .error_flags_high(error_flags_high),
      .second_mode_register(second_mode_register), .ot_status(ot_status),
      .scl_filt(scl_filt), .sda_filt(sda_filt));
   lfd_host host (.link_clk(link_clk), .start(go), .low_cyc(len), .pull(pull), .scl_in(scl_in),
      .sda_in(sda_in));

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #5;
      forever #16 link_clk = ~link_clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #10;
   endtask : step
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] d);
      mode_wr = 1'b1;
      mode_wdata = d;
      step(1);
      mode_wr = 1'b0;
      step(1);
      chk({8'h00, second_mode_register}, {8'h00, d});
   endtask : wr
   task automatic spike(input logic [1:0] sel, input logic [3:0] n, input logic [1:0] exp);
      pull = sel;
      len = n;
      go = ~go;
      acc = 2'h3;
      repeat (14) begin
         step(1);
         acc = acc & {sda_filt, scl_filt};
      end
      chk({14'h0000, acc}, {14'h0000, exp});
   endtask : spike
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      step(4);
      rst_n = 1'b1;
      led_on = 16'hFFFF;
      chk(drive_en, 16'h0000);
      chk({error_flags_high, error_flags_low}, 16'h0000);
      chk({8'h00, second_mode_register}, 16'h0000);
      chk({14'h0000, scl_filt, sda_filt}, 16'h0003);
      $display("reset defaults done");
      for (int i = 0; i < 7; i++) begin
         {led_on, pwm_active, cur_ok, ot_chan, e_d, e_f, e_o} = rows[i];
         step(5);
         chk(drive_en, e_d);
         chk({error_flags_high, error_flags_low}, e_f);
         chk(ot_status, e_o);
      end
      $display("table done");
      led_on = 16'hFFFF;
      ot_chan = 16'h0000;
      wr(8'h80);
      step(2);
      chk(ot_status, 16'h0000);
      chk({error_flags_high, error_flags_low}, 16'hFFFF);
      ot_global = 1'b1;
      step(5);
      chk(drive_en, 16'h0000);
      chk(ot_status, 16'h0000);
      ot_global = 1'b0;
      // let the synchronised trip fall before re-arming
      step(3);
      wr(8'h00);
      step(5);
      chk({error_flags_high, error_flags_low}, 16'hFFFF);
      ot_global = 1'b1;
      step(5);
      chk(drive_en, 16'h0000);
      chk({error_flags_high, error_flags_low}, 16'h0000);
      chk(ot_status, 16'hFFFF);
      ot_global = 1'b0;
      step(5);
      chk(drive_en, 16'hFFFF);
      chk({error_flags_high, error_flags_low}, 16'h0000);
      $display("overtemperature done");
      spike(2'h2, 4'h1, 2'h3);
      spike(2'h2, 4'h4, 2'h1);
      spike(2'h1, 4'h1, 2'h3);
      spike(2'h1, 4'h4, 2'h2);
      $display("spike filter done");
      // host line is idle here, so a reset cannot disturb a transfer
      rst_n = 1'b0;
      #20;
      chk(drive_en, 16'h0000);
      chk(ot_status, 16'h0000);
      chk({8'h00, second_mode_register}, 16'h0000);
      rst_n = 1'b1;
      step(1);
      chk({error_flags_high, error_flags_low}, 16'h0000);
      step(6);
      chk(drive_en, 16'hFFFF);
      $display("mid-run reset done");
      give_verdict();
   end
endmodule : lfd_fault_ctrl_bench
